// *** rtl/ccp_pkg.sv ***
// shared constants of the capture/compare/pwm unit
// assumes a 32-bit apb slave with word-aligned registers
package ccp_pkg;

  // ************************************************
  // register byte offsets
  // ************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PRESC  = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_TIMER  = 8'h0c;
  localparam logic [7:0] ADDR_CHCFG  = 8'h10;
  localparam logic [7:0] ADDR_CAPCFG = 8'h14;
  localparam logic [7:0] ADDR_CMPA   = 8'h18;
  localparam logic [7:0] ADDR_CMPB   = 8'h1c;
  localparam logic [7:0] ADDR_CMPC   = 8'h20;
  localparam logic [7:0] ADDR_CMPD   = 8'h24;
  localparam logic [7:0] ADDR_CAP0   = 8'h28;
  localparam logic [7:0] ADDR_CAP1   = 8'h2c;
  localparam logic [7:0] ADDR_IFLAG  = 8'h30;
  localparam logic [7:0] ADDR_IEN    = 8'h34;

  // ************************************************
  // sizes and field positions
  // ************************************************
  localparam int TMR_W    = 16;
  localparam int PRESC_W  = 10;
  localparam int PLLDIV_W = 4;
  localparam int EVCNT_W  = 4;
  localparam int NUM_CMP  = 4;
  localparam int NUM_CAP  = 2;
  localparam int NUM_IRQ  = 7;
  localparam int FILT_LEN = 4;
  localparam int IRQ_OVF  = 0;
  localparam int IRQ_CAP0 = 1;
  localparam int IRQ_CMP0 = 3;

  localparam logic [15:0]        TOP_WORD  = 16'hffff;
  localparam logic [15:0]        TOP_BYTE  = 16'h00ff;
  localparam logic [PRESC_W-1:0] PRESC_MAX = 10'h3ff;
  localparam logic [15:0]        RELOAD_RST = 16'h0000;
  localparam logic [15:0]        CMP_RST    = 16'h0000;

  typedef enum logic [1:0]
  {
    MODE_BASIC = 2'b00,
    MODE_ASYM  = 2'b01,
    MODE_SYM   = 2'b10
  } ccp_mode_e;

endpackage : ccp_pkg

// *** rtl/ccp_cap_if.sv ***
// link between the unit core and one capture channel
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface ccp_cap_if;
  logic        risingSel;
  logic        filtEn;
  logic [3:0]  evCount;
  logic [15:0] timerVal;
  logic        capEvent;
  logic [15:0] capValue;

  modport core
  (
    output risingSel, filtEn, evCount, timerVal,
    input  capEvent, capValue
  );
  modport chan
  (
    input  risingSel, filtEn, evCount, timerVal,
    output capEvent, capValue
  );
endinterface : ccp_cap_if

// *** rtl/ccp_capture.sv ***
// one capture channel: synchroniser, noise filter, edge select,
// event counter and capture register
// assumes rstSync_b is already synchronised to clk
`timescale 1ns/10ps
module ccp_capture
(
  input  wire logic clk,
  input  wire logic rstSync_b,
  input  wire logic capPin,
  ccp_cap_if.chan   cap
);

  logic                           sync1_r;
  logic                           sync2_r;
  logic [ccp_pkg::FILT_LEN-1:0]   hist_r;
  logic                           level_r;
  logic                           levelNxt;
  logic                           edgeHit;
  logic [ccp_pkg::EVCNT_W-1:0]    evCnt_r;
  logic                           capEvent_r;
  logic [15:0]                    capValue_r;

  // ************************************************
  // input sampling
  // ************************************************
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      hist_r  <= '0;
      level_r <= 1'b0;
    end
    else
    begin
      sync1_r <= capPin;
      sync2_r <= sync1_r;
      hist_r  <= {hist_r[ccp_pkg::FILT_LEN-2:0], sync2_r};
      level_r <= levelNxt;
    end
  end

  always_comb
  begin
    levelNxt = sync2_r;
    if (cap.filtEn)
    begin
      if (&hist_r)
        levelNxt = 1'b1; // R14
      else if (~|hist_r)
        levelNxt = 1'b0; // R14
      else
        levelNxt = level_r;
    end
  end

  assign edgeHit = (levelNxt != level_r) && (levelNxt == cap.risingSel); // R13

  // ************************************************
  // event counter and capture
  // ************************************************
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      evCnt_r    <= '0;
      capEvent_r <= 1'b0;
      capValue_r <= '0;
    end
    else
    begin
      capEvent_r <= 1'b0;
      if (edgeHit)
      begin
        if (evCnt_r >= cap.evCount) // R15
        begin
          evCnt_r    <= '0;
          capEvent_r <= 1'b1;
          capValue_r <= cap.timerVal; // R12
        end
        else
          evCnt_r <= evCnt_r + 4'h1;
      end
    end
  end

  assign cap.capEvent = capEvent_r;
  assign cap.capValue = capValue_r;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_b);

  a_cap_takes_timer : assert property ( // R12
    edgeHit && (evCnt_r >= cap.evCount)
      |=> capEvent_r && capValue_r == $past(cap.timerVal))
    else $error("capture did not copy the timer value");

  a_filter_four_samples : assert property ( // R14
    cap.filtEn && (levelNxt != level_r) |-> (&hist_r) || (~|hist_r))
    else $error("filtered level changed without four equal samples");

endmodule : ccp_capture

// *** rtl/ccp_unit.sv ***
// capture/compare/pwm unit with apb register access
// assumes apb master on clk; capture pins are asynchronous
//
// Overview of operation
// (R1) 16-bit timer reloads a programmable value at every overflow; in symmetrical mode it turns at the reload value and restarts at 1 after zero.
// (R2) 10-bit prescaler reloads at overflow, dividing by 1 to 1024.
// (R3) core clock is peripheral clock in timer mode, pll in pwm modes.
// (R4) pll takes 0.5 to 1 mhz and multiplies by 32; the unit has no multiplier, pwm modes step once per divided reference tick.
// (R5) pll input is peripheral clock divided by 4-bit field plus one.
// (R6) direction bit sets count direction; changing it reverses at once.
// (R7) timer readable and writable any time with coherent 16-bit access.
// (R8) every reload sets overflow flag; interrupt when enabled.
// (R9) timer may run as 8-bit up/down counter.
// (R10) software enables each compare channel and sets its pin mode.
// (R11) timer equal to compare sets match flag; interrupt when enabled.
// (R12) capture always active; event copies timer into capture register.
// (R13) each capture input selects rising or falling edge.
// (R14) filter accepts an edge after four equal samples.
// (R15) event counter delays capture by a set number of events.
// (R16) asymmetrical pwm always counts down.
// (R17) symmetrical pwm counts up and down; compare makes waveform.
// (R18) newly connected pin keeps hold-bit level; then only compare changes it. In asymmetrical mode overflow also sets the level high.
// (R19) alternating pairs a/b and c/d gated on alternate counter cycles.
// (R20) seven interrupt sources share one request.
// (R21) each compare output has selectable polarity.
// (R22) flags stay set until cleared; a new event wins over clear.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module ccp_unit
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  capPin,
  output logic      [3:0]  pwmOut,
  output logic             irq
);

  localparam int NC = ccp_pkg::NUM_CMP;
  localparam int NP = ccp_pkg::NUM_CAP;
  localparam int NI = ccp_pkg::NUM_IRQ;

  logic                  rstMeta_r;
  logic                  rstSync_b;
  ccp_pkg::ccp_mode_e    mode_r;
  logic                  dirDown_r;
  logic                  run_r;
  logic                  byteMode_r;
  logic                  altAb_r;
  logic                  altCd_r;
  logic [3:0]            pllDiv_r;
  logic [3:0]            pllCnt_r;
  logic                  pllTick_r;
  logic [9:0]            prescReload_r;
  logic [9:0]            presc_r;
  logic [15:0]           reload_r;
  logic [15:0]           timer_r;
  logic [15:0]           timerNxt;
  logic                  symDown_r;
  logic                  symDownNxt;
  logic                  phase_r;
  logic [NC-1:0]         chEn_r;
  logic [NC-1:0]         pol_r;
  logic [NC-1:0]         hold_r;
  logic [NP-1:0]         capRise_r;
  logic [NP-1:0]         filtEn_r;
  logic [7:0]            evCfg_r;
  logic [NC-1:0][15:0]   cmp_r;
  logic [NI-1:0]         flag_r;
  logic [NI-1:0]         ien_r;
  logic [NI-1:0]         flagSet;
  logic [NI-1:0]         flagClr;
  logic [NC-1:0]         cmpMatch;
  logic [NC-1:0]         outLevel;
  logic [NP-1:0]         capEvent;
  logic [NP-1:0][15:0]   capVal;
  logic [15:0]           top;
  logic                  coreTick;
  logic                  stepEn;
  logic                  countDown;
  logic                  ovfEvent;
  logic                  wrEn;
  logic                  rdAccess;
  logic [31:0]           rdData;
  logic                  unmapped;
  logic                  pready_r;
  logic [31:0]           prdata_r;
  logic                  pslverr_r;
  logic                  irq_r;

  // ************************************************
  // reset release
  // ************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_r <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_b <= rstMeta_r;
    end
  end

  // ************************************************
  // apb slave: one wait state, write at completion
  // ************************************************
  assign rdAccess = psel && penable && !pready_r;
  assign wrEn     = psel && penable && pready_r && pwrite;

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= rdAccess;
      pslverr_r <= rdAccess && unmapped;
      if (rdAccess && !pwrite)
        prdata_r <= rdData; // R7
    end
  end

  always_comb
  begin
    rdData   = '0;
    unmapped = 1'b0;
    case (paddr)
      ccp_pkg::ADDR_CTRL:
        rdData = {20'h00000, pllDiv_r, 1'b0, altCd_r, altAb_r, byteMode_r,
                  run_r, dirDown_r, mode_r};
      ccp_pkg::ADDR_PRESC:  rdData = {22'h000000, prescReload_r};
      ccp_pkg::ADDR_RELOAD: rdData = {16'h0000, reload_r};
      ccp_pkg::ADDR_TIMER:  rdData = {16'h0000, timer_r};
      ccp_pkg::ADDR_CHCFG:
        rdData = {16'h0000, filtEn_r, capRise_r, hold_r, pol_r, chEn_r};
      ccp_pkg::ADDR_CAPCFG: rdData = {24'h000000, evCfg_r};
      ccp_pkg::ADDR_CMPA:   rdData = {16'h0000, cmp_r[0]};
      ccp_pkg::ADDR_CMPB:   rdData = {16'h0000, cmp_r[1]};
      ccp_pkg::ADDR_CMPC:   rdData = {16'h0000, cmp_r[2]};
      ccp_pkg::ADDR_CMPD:   rdData = {16'h0000, cmp_r[3]};
      ccp_pkg::ADDR_CAP0:   rdData = {16'h0000, capVal[0]};
      ccp_pkg::ADDR_CAP1:   rdData = {16'h0000, capVal[1]};
      ccp_pkg::ADDR_IFLAG:  rdData = {25'h0000000, flag_r};
      ccp_pkg::ADDR_IEN:    rdData = {25'h0000000, ien_r};
      default:              unmapped = 1'b1;
    endcase
  end

  // ************************************************
  // configuration registers
  // ************************************************
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      mode_r        <= ccp_pkg::MODE_BASIC;
      dirDown_r     <= 1'b0;
      run_r         <= 1'b0;
      byteMode_r    <= 1'b0;
      altAb_r       <= 1'b0;
      altCd_r       <= 1'b0;
      pllDiv_r      <= '0;
      prescReload_r <= ccp_pkg::PRESC_MAX;
      reload_r      <= ccp_pkg::RELOAD_RST;
      chEn_r        <= '0;
      pol_r         <= '0;
      hold_r        <= '0;
      capRise_r     <= '0;
      filtEn_r      <= '0;
      evCfg_r       <= '0;
      cmp_r         <= '0;
      ien_r         <= '0;
    end
    else if (wrEn)
    begin
      case (paddr)
        ccp_pkg::ADDR_CTRL:
        begin
          mode_r     <= ccp_pkg::ccp_mode_e'(pwdata[1:0]);
          dirDown_r  <= pwdata[2]; // R6
          run_r      <= pwdata[3];
          byteMode_r <= pwdata[4]; // R9
          altAb_r    <= pwdata[5]; // R19
          altCd_r    <= pwdata[6]; // R19
          pllDiv_r   <= pwdata[11:8]; // R5
        end
        ccp_pkg::ADDR_PRESC:  prescReload_r <= pwdata[9:0];
        ccp_pkg::ADDR_RELOAD: reload_r <= pwdata[15:0];
        ccp_pkg::ADDR_CHCFG:
        begin
          chEn_r    <= pwdata[3:0];
          pol_r     <= pwdata[7:4]; // R21
          hold_r    <= pwdata[11:8];
          capRise_r <= pwdata[13:12]; // R13
          filtEn_r  <= pwdata[15:14];
        end
        ccp_pkg::ADDR_CAPCFG: evCfg_r <= pwdata[7:0]; // R15
        ccp_pkg::ADDR_CMPA:   cmp_r[0] <= pwdata[15:0];
        ccp_pkg::ADDR_CMPB:   cmp_r[1] <= pwdata[15:0];
        ccp_pkg::ADDR_CMPC:   cmp_r[2] <= pwdata[15:0];
        ccp_pkg::ADDR_CMPD:   cmp_r[3] <= pwdata[15:0];
        ccp_pkg::ADDR_IEN:    ien_r <= pwdata[6:0];
        default:              ;
      endcase
    end
  end

  // ************************************************
  // core clock rate and prescaler
  // ************************************************
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      pllCnt_r  <= '0;
      pllTick_r <= 1'b0;
    end
    else if (pllCnt_r >= pllDiv_r)
    begin
      pllCnt_r  <= '0; // R5
      pllTick_r <= 1'b1; // R4
    end
    else
    begin
      pllCnt_r  <= pllCnt_r + 4'h1;
      pllTick_r <= 1'b0;
    end
  end

  // pwm modes run off the pll reference rate, basic mode every clock
  assign coreTick = (mode_r == ccp_pkg::MODE_BASIC) ? 1'b1 : pllTick_r; // R3

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      presc_r <= ccp_pkg::PRESC_MAX;
    else if (run_r && coreTick)
    begin
      if (presc_r == ccp_pkg::PRESC_MAX)
        presc_r <= prescReload_r; // R2
      else
        presc_r <= presc_r + 10'h001;
    end
  end

  assign stepEn = run_r && coreTick && (presc_r == ccp_pkg::PRESC_MAX);

  // ************************************************
  // timer
  // ************************************************
  assign top       = byteMode_r ? ccp_pkg::TOP_BYTE : ccp_pkg::TOP_WORD; // R9
  assign countDown = (mode_r == ccp_pkg::MODE_ASYM) ? 1'b1 : dirDown_r; // R16

  always_comb
  begin
    timerNxt   = timer_r;
    symDownNxt = (mode_r == ccp_pkg::MODE_SYM) ? symDown_r : 1'b0;
    ovfEvent   = 1'b0;
    if (stepEn)
    begin
      if (mode_r == ccp_pkg::MODE_SYM) // R17
      begin
        if (!symDown_r)
        begin
          if (timer_r >= (reload_r & top))
          begin
            symDownNxt = 1'b1;
            timerNxt   = timer_r - 16'h0001;
          end
          else
            timerNxt = timer_r + 16'h0001;
        end
        else if (timer_r == 16'h0000)
        begin
          symDownNxt = 1'b0;
          timerNxt   = 16'h0001;
          ovfEvent   = 1'b1;
        end
        else
          timerNxt = timer_r - 16'h0001;
      end
      else if (countDown) // R6
      begin
        if (timer_r == 16'h0000)
        begin
          timerNxt = reload_r & top; // R1
          ovfEvent = 1'b1;
        end
        else
          timerNxt = timer_r - 16'h0001;
      end
      else if (timer_r == top)
      begin
        timerNxt = reload_r & top; // R1
        ovfEvent = 1'b1;
      end
      else
        timerNxt = timer_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      timer_r   <= '0;
      symDown_r <= 1'b0;
      phase_r   <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == ccp_pkg::ADDR_TIMER)
        timer_r <= pwdata[15:0] & top; // R7
      else
        timer_r <= timerNxt;
      symDown_r <= symDownNxt;
      if (ovfEvent)
        phase_r <= !phase_r; // R19
    end
  end

  // ************************************************
  // capture channels
  // ************************************************
  ccp_cap_if capIf[NP] ();

  for (genvar g = 0; g < NP; g++)
  begin : g_cap
    assign capIf[g].risingSel = capRise_r[g];
    assign capIf[g].filtEn    = filtEn_r[g];
    assign capIf[g].evCount   = evCfg_r[g*4 +: 4];
    assign capIf[g].timerVal  = timer_r;
    assign capEvent[g]        = capIf[g].capEvent;
    assign capVal[g]          = capIf[g].capValue;

    ccp_capture u_cap
    (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .capPin    (capPin[g]),
      .cap       (capIf[g])
    );
  end

  // ************************************************
  // compare channels and outputs
  // ************************************************
  for (genvar g = 0; g < NC; g++)
  begin : g_cmp
    localparam logic CH_ODD = (g % 2) == 1;
    logic level_r;
    logic pin_r;
    logic altOn;
    logic gateOn;

    assign cmpMatch[g] = stepEn && (timer_r == (cmp_r[g] & top)); // R11
    assign altOn  = (mode_r == ccp_pkg::MODE_ASYM) &&
                    ((g < 2) ? altAb_r : altCd_r);
    assign gateOn = !altOn || (phase_r == CH_ODD); // R19
    assign outLevel[g] = level_r;
    assign pwmOut[g]   = pin_r;

    always_ff @(posedge clk or negedge rstSync_b)
    begin
      if (!rstSync_b)
      begin
        level_r <= 1'b0;
        pin_r   <= 1'b0;
      end
      else
      begin
        if (!chEn_r[g])
          level_r <= hold_r[g]; // R18
        else if (cmpMatch[g])
        begin
          case (mode_r)
            ccp_pkg::MODE_ASYM: level_r <= 1'b0;
            ccp_pkg::MODE_SYM:  level_r <= !symDown_r; // R17
            default:            level_r <= !level_r;
          endcase
        end
        else if (ovfEvent && mode_r == ccp_pkg::MODE_ASYM)
          level_r <= 1'b1;
        pin_r <= (level_r && gateOn) ^ pol_r[g]; // R21
      end
    end
  end

  // ************************************************
  // flags and interrupt request
  // ************************************************
  always_comb
  begin
    flagSet = {cmpMatch, capEvent, ovfEvent}; // R20
    flagClr = '0;
    if (wrEn && paddr == ccp_pkg::ADDR_IFLAG)
      flagClr = pwdata[6:0];
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      flag_r <= '0;
      irq_r  <= 1'b0;
    end
    else
    begin
      flag_r <= (flag_r & ~flagClr) | flagSet; // R22
      irq_r  <= |(flag_r & ien_r); // R8
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_b);

  sequence s_enable_a;
    !chEn_r[0] ##1 chEn_r[0];
  endsequence

  a_ovf_sets_flag : assert property ( // R8
    ovfEvent |=> flag_r[ccp_pkg::IRQ_OVF] ##1
      (irq_r || !$past(ien_r[ccp_pkg::IRQ_OVF])))
    else $error("reload did not set the overflow flag");

  a_match_sets_flag : assert property ( // R11
    cmpMatch[0] |=> flag_r[ccp_pkg::IRQ_CMP0])
    else $error("compare match did not set its flag");

  a_flag_clear_only : assert property ( // R22
    $fell(flag_r[ccp_pkg::IRQ_CAP0]) |-> $past(flagClr[1]))
    else $error("flag fell without a clear");

  a_irq_follows : assert property ( // R20
    ((flag_r & ien_r) != '0) |=> irq_r)
    else $error("enabled flag gave no request");

  a_asym_counts_down : assert property ( // R16
    stepEn && mode_r == ccp_pkg::MODE_ASYM && timer_r != 16'h0000
      && !wrEn |=> timer_r == $past(timer_r) - 16'h0001)
    else $error("asymmetrical mode did not count down");

  a_presc_reload : assert property ( // R2
    run_r && coreTick && presc_r == ccp_pkg::PRESC_MAX
      |=> presc_r == $past(prescReload_r))
    else $error("prescaler did not reload");

  a_pin_holds_level : assert property ( // R18
    s_enable_a ##0 (!cmpMatch[0] && !ovfEvent) |=> $stable(outLevel[0]))
    else $error("pin changed on connection");

  a_byte_range : assert property ( // R9
    byteMode_r && $past(byteMode_r) && stepEn |=> timer_r <= ccp_pkg::TOP_BYTE)
    else $error("8-bit timer left its range");

endmodule : ccp_unit

// *** bench/ccp_cap_src.sv ***
// capture signal source standing on the far side of the capture pins
// assumes the bench asks for pin levels in step with clk
`timescale 1ns/10ps
module ccp_cap_src
(
  input  wire logic       clk,
  input  wire logic [1:0] wantLvl,
  output logic      [1:0] capPin
);
  // the source changes its pins only just after a clock edge
  initial capPin = 2'h0;
  always @(posedge clk)
  begin
    capPin <= wantLvl;
  end
endmodule : ccp_cap_src

// *** bench/capture_compare_pwm_unit_tb_top.sv ***
// self-checking bench of the capture/compare/pwm unit
// assumes ccp_unit with apb slave and the capture source model
`timescale 1ns/10ps
module capture_compare_pwm_unit_tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d;} ccp_row_s;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0]  want, capPin;
  logic [3:0]  pwmOut;
  logic        lastErr;
  int          badCount, numChecks, cyc;
  ccp_row_s    rows [8];

  ccp_unit uut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capPin(capPin),
    .pwmOut(pwmOut), .irq(irq));
  ccp_cap_src src (.clk(clk), .wantLvl(want), .capPin(capPin));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      badCount++;
      wrap_up();
    end
  end

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask : rdchk

  task automatic run(input logic [31:0] ctrl, input int n);
    apb(ccp_pkg::ADDR_CTRL, 1'b1, ctrl);
    repeat (n) @(posedge clk);
    apb(ccp_pkg::ADDR_CTRL, 1'b1, 32'h0);
    apb(ccp_pkg::ADDR_TIMER, 1'b0, 32'h0);
  endtask : run

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; want = 2'h0;
    badCount = 0; numChecks = 0; cyc = 0;
    rows = '{'{ccp_pkg::ADDR_CTRL, 32'h00000f61},
             '{ccp_pkg::ADDR_PRESC, 32'h00000155},
             '{ccp_pkg::ADDR_RELOAD, 32'h0000abcd},
             '{ccp_pkg::ADDR_CMPA, 32'h00001111},
             '{ccp_pkg::ADDR_CMPB, 32'h00000200},
             '{ccp_pkg::ADDR_CMPC, 32'h00003000},
             '{ccp_pkg::ADDR_CAPCFG, 32'h00000021},
             '{ccp_pkg::ADDR_IEN, 32'h0000007f}};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(ccp_pkg::ADDR_PRESC, 32'h000003ff);
    rdchk(ccp_pkg::ADDR_CTRL, 32'h0);
    foreach (rows[i])
    begin
      apb(rows[i].a, 1'b1, rows[i].d);
      rdchk(rows[i].a, rows[i].d);
    end
    apb(8'h40, 1'b1, 32'h5a5a5a5a);
    rdchk(8'h40, 32'h0);
    chk({31'h0, lastErr}, 32'h1);
    apb(ccp_pkg::ADDR_PRESC, 1'b1, 32'h3ff);
    apb(ccp_pkg::ADDR_CAPCFG, 1'b1, 32'h0);
    apb(ccp_pkg::ADDR_IEN, 1'b1, 32'h1);
    apb(ccp_pkg::ADDR_CMPA, 1'b1, 32'h0120);
    apb(ccp_pkg::ADDR_RELOAD, 1'b1, 32'h0100);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'hfff0);
    apb(ccp_pkg::ADDR_IFLAG, 1'b1, 32'h7f);
    run(32'h08, 80);
    chk({31'h0, rv[15:0] > 16'h0120 && rv[15:0] < 16'h0200}, 32'h1);
    rdchk(ccp_pkg::ADDR_IFLAG, 32'h09);
    chk({31'h0, irq}, 32'h1);
    apb(ccp_pkg::ADDR_IFLAG, 1'b1, 32'h01);
    rdchk(ccp_pkg::ADDR_IFLAG, 32'h08);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h0050);
    run(32'h0c, 20);
    chk({31'h0, rv[15:0] < 16'h0050 && rv[15:0] > 16'h0030}, 32'h1);
    apb(ccp_pkg::ADDR_RELOAD, 1'b1, 32'h0010);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h00f0);
    run(32'h18, 40);
    chk({31'h0, rv[15:0] < 16'h0100 && rv[15:0] >= 16'h0010}, 32'h1);
    apb(ccp_pkg::ADDR_CHCFG, 1'b1, 32'h0500);
    repeat (4) @(posedge clk);
    chk({28'h0, pwmOut}, 32'h5);
    apb(ccp_pkg::ADDR_CHCFG, 1'b1, 32'h0511);
    repeat (4) @(posedge clk);
    chk({28'h0, pwmOut}, 32'h4);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h011e);
    run(32'h08, 4);
    chk({28'h0, pwmOut}, 32'h5);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h0080);
    run(32'h09, 20);
    chk({31'h0, rv[15:0] < 16'h0080 && rv[15:0] > 16'h0060}, 32'h1);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h0008);
    run(32'h0a, 12);
    chk({31'h0, rv[15:0] < 16'h0010 && rv[15:0] > 16'h0004}, 32'h1);
    apb(ccp_pkg::ADDR_CHCFG, 1'b1, 32'h1000);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h1234);
    want <= 2'h3;
    repeat (10) @(posedge clk);
    rdchk(ccp_pkg::ADDR_CAP0, 32'h1234);
    rdchk(ccp_pkg::ADDR_CAP1, 32'h0);
    want <= 2'h1;
    repeat (10) @(posedge clk);
    rdchk(ccp_pkg::ADDR_CAP1, 32'h1234);
    apb(ccp_pkg::ADDR_CHCFG, 1'b1, 32'h5000);
    apb(ccp_pkg::ADDR_TIMER, 1'b1, 32'h2222);
    want <= 2'h0;
    repeat (2) @(posedge clk);
    want <= 2'h1;
    repeat (10) @(posedge clk);
    rdchk(ccp_pkg::ADDR_CAP0, 32'h1234);
    want <= 2'h0;
    repeat (8) @(posedge clk);
    want <= 2'h1;
    repeat (12) @(posedge clk);
    rdchk(ccp_pkg::ADDR_CAP0, 32'h2222);
    chk({31'h0, irq}, 32'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(ccp_pkg::ADDR_CAP0, 32'h0);
    rdchk(ccp_pkg::ADDR_IFLAG, 32'h0);
    wrap_up();
  end
endmodule : capture_compare_pwm_unit_tb_top
